// [logic/i2c_arbitration_address_monitor.v]
// Two-wire bus arbitration, address match and start generation block
`timescale 1ns/1ns
`default_nettype none
`include "i2c_monitor_regs.vh"

module i2c_arbitration_address_monitor (
	// Clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// Configuration
	input wire interface_mode_select_i,
	input wire ack_clock_en_i,
	input wire detection_disable_i,
	input wire [2:0] word_bit_count_i,
	input wire address_recognition_select_i,
	input wire [6:0] own_slave_address_i,
	// Data buffer access
	input wire data_buffer_wr_i,
	input wire data_buffer_rd_i,
	input wire [7:0] data_buffer_wdata_i,
	output reg [7:0] data_buffer_rdata_o,
	// Second control register write
	input wire control_two_wr_i,
	input wire cr2_master_select_i,
	input wire cr2_transmitter_select_i,
	input wire cr2_bus_busy_i,
	input wire cr2_pending_service_i,
	// Status
	output reg master_select_o,
	output reg transmitter_select_o,
	output reg bus_busy_bit_o,
	output reg pending_service_o,
	output reg arbitration_lost_flag_o,
	output reg address_match_flag_o,
	output reg general_call_flag_o,
	output reg last_received_bit_o,
	output reg serial_iface_irq_o,
	// Open-drain bus pins
	input wire clock_line_pin_i,
	output reg clock_line_pin_o,
	output reg clock_line_pin_oe_o,
	input wire data_line_pin_i,
	output reg data_line_pin_o,
	output reg data_line_pin_oe_o
);

// ==========================================================
// Master clock generator states
localparam ST_IDLE = 2'b00;
localparam ST_START = 2'b01;
localparam ST_LOW = 2'b10;
localparam ST_HIGH = 2'b11;

// Data bits per word; code zero means a full byte
function [`BIT_CNT_W-1:0] word_bits;
	input [2:0] code;
	begin
		if (code == 3'h0)
			word_bits = `FULL_WORD_BITS;
		else
			word_bits = {1'b0, code};
	end
endfunction

// ==========================================================
// Line synchronisers
wire scl_lvl;
wire scl_rise;
wire scl_fall;
wire sda_lvl;
wire sda_rise;
wire sda_fall;

line_sync u_scl_sync (
	.clock_i(clock_i),
	.rst_n_i(rst_n_i),
	.line_i(clock_line_pin_i),
	.level_o(scl_lvl),
	.rise_o(scl_rise),
	.fall_o(scl_fall)
);

line_sync u_sda_sync (
	.clock_i(clock_i),
	.rst_n_i(rst_n_i),
	.line_i(data_line_pin_i),
	.level_o(sda_lvl),
	.rise_o(sda_rise),
	.fall_o(sda_fall)
);

// ==========================================================
// Internal state
reg [1:0] state_reg;
reg [7:0] tx_reg;
reg [`BIT_CNT_W-1:0] bit_cnt_reg;
reg first_word_reg;
reg addressed_reg;
reg dir_reg;
reg hold_reg;

// Phase timer shared by master clocking and slave clock hold
reg timer_load;
reg [`TIMER_W-1:0] timer_value;
wire timer_done;

phase_timer u_timer (
	.clock_i(clock_i),
	.rst_n_i(rst_n_i),
	.load_i(timer_load),
	.value_i(timer_value),
	.done_o(timer_done)
);

// ==========================================================
// Bus conditions and word framing
wire start_det = sda_fall & scl_lvl;
wire stop_det = sda_rise & scl_lvl;
wire [`BIT_CNT_W-1:0] data_bits =
	word_bits(master_select_o ? word_bit_count_i : 3'h0);
wire [`BIT_CNT_W-1:0] word_len =
	data_bits + {{(`BIT_CNT_W-1){1'b0}}, ack_clock_en_i};
wire in_data = (bit_cnt_reg < data_bits);
wire in_ack = ack_clock_en_i & (bit_cnt_reg == data_bits);
wire tx_bit = tx_reg[`MSB_INDEX - bit_cnt_reg[2:0]];
wire word_done = scl_fall & bus_busy_bit_o & (bit_cnt_reg == word_len);
wire [7:0] rx_byte = {data_buffer_rdata_o[6:0], sda_lvl};

// Software strobes
wire sw_buffer = data_buffer_wr_i | data_buffer_rd_i;
wire start_cmd = control_two_wr_i & cr2_master_select_i &
	cr2_transmitter_select_i & cr2_bus_busy_i & cr2_pending_service_i &
	~bus_busy_bit_o;
wire pin_set = data_buffer_wr_i |
	(control_two_wr_i & cr2_pending_service_i);

// Loss only while clocking as master and releasing data high
wire al_hit = scl_rise & master_select_o & transmitter_select_o &
	in_data & (state_reg != ST_IDLE) & ~data_line_pin_oe_o &
	~sda_lvl;

// Address check at the eighth rise of the first word, slave only
wire addr_chk = scl_rise & first_word_reg &
	(bit_cnt_reg == `LAST_ADDR_BIT) & ~master_select_o &
	~address_recognition_select_i & ~detection_disable_i;
wire gc_hit = addr_chk & (rx_byte == `GENERAL_CALL_BYTE);
wire sa_hit = addr_chk & (rx_byte[7:1] == own_slave_address_i);
wire free_first = word_done & first_word_reg & ~master_select_o &
	address_recognition_select_i;

// Words that end in an interrupt and a held clock
wire serviced = master_select_o | arbitration_lost_flag_o |
	addressed_reg | free_first;
wire irq_now = word_done & serviced;

// ==========================================================
// Data line drive: own data, slave data, or acknowledge
wire transmitting = transmitter_select_o &
	(master_select_o | (addressed_reg & ~first_word_reg));
wire ack_drive = in_ack & (first_word_reg ?
	(~master_select_o & addressed_reg) :
	(~transmitter_select_o & (master_select_o | addressed_reg)));
wire sda_want = (transmitting & in_data & ~tx_bit) | ack_drive;

// ==========================================================
// Master clock generator and timer control
always @*
begin
	timer_load = 1'b0;
	timer_value = `LOW_CYC;
	case (state_reg)
		ST_IDLE:
		begin
			timer_load = start_cmd;
			timer_value = `HIGH_CYC;
		end
		ST_START:
			timer_load = timer_done;
		ST_LOW:
			timer_load = pin_set;
		ST_HIGH:
		begin
			// Count high time only once the bus line is seen high
			timer_load = ~scl_lvl | timer_done;
			timer_value = scl_lvl ? `LOW_CYC : `HIGH_CYC;
		end
		default:
			timer_load = 1'b0;
	endcase
	// Slave hold release counts the low time after service
	if (state_reg == ST_IDLE && hold_reg && pin_set)
	begin
		timer_load = 1'b1;
		timer_value = `LOW_CYC;
	end
end

// State advance; a lost arbitration drops out at once
always @(posedge clock_i)
begin
	if (!rst_n_i || !interface_mode_select_i)
		state_reg <= ST_IDLE;
	else if (al_hit || !master_select_o && state_reg != ST_IDLE)
		state_reg <= ST_IDLE;
	else
	begin
		case (state_reg)
			ST_IDLE:
				if (start_cmd)
					state_reg <= ST_START;
			ST_START:
				if (timer_done)
					state_reg <= ST_LOW;
			ST_LOW:
				// Held low while service is pending
				if (timer_done && pending_service_o && !pin_set)
					state_reg <= ST_HIGH;
			ST_HIGH:
				if (scl_lvl && timer_done)
					state_reg <= ST_LOW;
			default:
				state_reg <= ST_IDLE;
		endcase
	end
end

// ==========================================================
// Pin drivers; levels are always low, only enables move
always @(posedge clock_i)
begin
	if (!rst_n_i || !interface_mode_select_i)
	begin
		clock_line_pin_o <= 1'b0;
		clock_line_pin_oe_o <= 1'b0;
		data_line_pin_o <= 1'b0;
		data_line_pin_oe_o <= 1'b0;
	end
	else
	begin
		clock_line_pin_o <= 1'b0;
		data_line_pin_o <= 1'b0;
		clock_line_pin_oe_o <= (state_reg == ST_LOW) | hold_reg;
		if (state_reg == ST_START)
			data_line_pin_oe_o <= 1'b1;
		else if (al_hit)
			data_line_pin_oe_o <= 1'b0;
		else if (!scl_lvl)
			// Data changes only while the clock is low
			data_line_pin_oe_o <= sda_want;
	end
end

// ==========================================================
// Word framing, shift registers and captured direction
always @(posedge clock_i)
begin
	if (!rst_n_i)
	begin
		bit_cnt_reg <= `BIT_CNT_ZERO;
		first_word_reg <= 1'b0;
		tx_reg <= `BYTE_RESET;
		data_buffer_rdata_o <= `BYTE_RESET;
		last_received_bit_o <= 1'b0;
		dir_reg <= 1'b0;
	end
	else
	begin
		if (start_det)
		begin
			bit_cnt_reg <= `BIT_CNT_ZERO;
			first_word_reg <= 1'b1;
		end
		else if (word_done)
		begin
			bit_cnt_reg <= `BIT_CNT_ZERO;
			first_word_reg <= 1'b0;
		end
		else if (scl_rise)
			bit_cnt_reg <= bit_cnt_reg + `BIT_CNT_ONE;
		if (scl_rise)
		begin
			last_received_bit_o <= sda_lvl;
			data_buffer_rdata_o <= rx_byte;
		end
		if (data_buffer_wr_i)
			tx_reg <= data_buffer_wdata_i;
		if (start_cmd)
			dir_reg <= tx_reg[0];
	end
end

// ==========================================================
// Mode bits, busy, pending service and interrupt
always @(posedge clock_i)
begin
	if (!rst_n_i)
	begin
		master_select_o <= 1'b0;
		transmitter_select_o <= 1'b0;
		bus_busy_bit_o <= 1'b0;
		pending_service_o <= `PIN_RESET;
		serial_iface_irq_o <= 1'b0;
		hold_reg <= 1'b0;
	end
	else
	begin
		serial_iface_irq_o <= irq_now;
		if (start_det)
			bus_busy_bit_o <= 1'b1;
		else if (stop_det)
			bus_busy_bit_o <= 1'b0;
		// Hardware clear wins so a finished word is never missed
		if (irq_now)
			pending_service_o <= 1'b0;
		else if (pin_set)
			pending_service_o <= 1'b1;
		if (al_hit || stop_det)
		begin
			master_select_o <= 1'b0;
			transmitter_select_o <= 1'b0;
		end
		else if (start_cmd)
		begin
			master_select_o <= 1'b1;
			transmitter_select_o <= 1'b1;
		end
		else if (sa_hit && !gc_hit)
			transmitter_select_o <= rx_byte[0];
		else if (word_done && master_select_o && first_word_reg &&
			!address_recognition_select_i)
		begin
			if (!last_received_bit_o)
				transmitter_select_o <= ~dir_reg;
		end
		else if (control_two_wr_i)
		begin
			master_select_o <= cr2_master_select_i;
			transmitter_select_o <= cr2_transmitter_select_i;
		end
		// Slave or lost master holds the clock until serviced
		if (irq_now && !master_select_o)
			hold_reg <= 1'b1;
		else if (hold_reg && timer_done && pending_service_o && !pin_set)
			hold_reg <= 1'b0;
		else if (!interface_mode_select_i)
			hold_reg <= 1'b0;
	end
end

// ==========================================================
// Monitor flags; an event beats a clear in the same cycle, except addressed_reg, where a start or stop beats a match
always @(posedge clock_i)
begin
	if (!rst_n_i)
	begin
		arbitration_lost_flag_o <= 1'b0;
		address_match_flag_o <= 1'b0;
		general_call_flag_o <= 1'b0;
		addressed_reg <= 1'b0;
	end
	else
	begin
		if (al_hit)
			arbitration_lost_flag_o <= 1'b1;
		else if (sw_buffer || control_two_wr_i)
			arbitration_lost_flag_o <= 1'b0;
		if (sa_hit || gc_hit || free_first)
			address_match_flag_o <= 1'b1;
		else if (sw_buffer)
			address_match_flag_o <= 1'b0;
		if (gc_hit)
			general_call_flag_o <= 1'b1;
		else if (start_det || stop_det)
			general_call_flag_o <= 1'b0;
		if (start_det || stop_det)
			addressed_reg <= 1'b0;
		else if (sa_hit || gc_hit || free_first)
			addressed_reg <= 1'b1;
	end
end

endmodule // i2c_arbitration_address_monitor

`default_nettype wire

// [logic/i2c_monitor_regs.vh]
// Constants for the two-wire arbitration and address monitor
`ifndef I2C_MONITOR_REGS_VH
`define I2C_MONITOR_REGS_VH

// ==========================================================
// Clock and bus timing, counted in 10 ns system clock cycles
`define TIMER_W 12
// High phase of 4000 ns
`define HIGH_CYC 12'h190
// Low phase of 4700 ns; also the slave release delay
`define LOW_CYC 12'h1d6

// ==========================================================
// Word framing
`define BIT_CNT_W 4
`define FULL_WORD_BITS 4'h8
`define LAST_ADDR_BIT 4'h7
`define MSB_INDEX 3'h7
`define BIT_CNT_ZERO 4'h0
`define BIT_CNT_ONE 4'h1
`define GENERAL_CALL_BYTE 8'h00

// ==========================================================
// Reset values
`define PIN_RESET 1'b1
`define BYTE_RESET 8'h00

`endif

// [logic/line_sync.v]
// Two-flop synchroniser with edge detection for one bus line
`timescale 1ns/1ns
`default_nettype none

module line_sync (
	// Clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// Asynchronous line
	input wire line_i,
	// Synchronised level and edges
	output wire level_o,
	output wire rise_o,
	output wire fall_o
);

// ==========================================================
// Synchroniser stages; first stage feeds only the second
reg meta_reg;
reg level_reg;
reg last_reg;

// Idle bus is high, so reset to high to avoid a false edge
always @(posedge clock_i)
begin
	if (!rst_n_i)
	begin
		meta_reg <= 1'b1;
		level_reg <= 1'b1;
		last_reg <= 1'b1;
	end
	else
	begin
		meta_reg <= line_i;
		level_reg <= meta_reg;
		last_reg <= level_reg;
	end
end

// Edges from the settled stages only
assign level_o = level_reg;
assign rise_o = level_reg & ~last_reg;
assign fall_o = ~level_reg & last_reg;

endmodule // line_sync

`default_nettype wire

// [logic/phase_timer.v]
// Down counter that times the bus clock high and low phases
`timescale 1ns/1ns
`default_nettype none
`include "i2c_monitor_regs.vh"

module phase_timer (
	// Clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// Load request
	input wire load_i,
	input wire [`TIMER_W-1:0] value_i,
	// Expiry level
	output wire done_o
);

// ==========================================================
reg [`TIMER_W-1:0] count_reg;

// Load wins; otherwise count down to zero and stay there
always @(posedge clock_i)
begin
	if (!rst_n_i)
		count_reg <= {`TIMER_W{1'b0}};
	else if (load_i)
		count_reg <= value_i;
	else if (count_reg != {`TIMER_W{1'b0}})
		count_reg <= count_reg - {{(`TIMER_W-1){1'b0}}, 1'b1};
end

assign done_o = (count_reg == {`TIMER_W{1'b0}});

endmodule // phase_timer

`default_nettype wire

// [tb/bus_master_model.sv]
// Other bus master driving the two open-drain lines
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Master model, 80 ns bit period
module bus_master_model (
	// Resolved lines
	input wire logic scl_i,
	input wire logic sda_i,
	// Pull-low enables
	output logic scl_oe_o,
	output logic sda_oe_o
);
	int stuck;
	// Lines released at start
	initial
	begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
		stuck = 0;
	end
	task automatic hold(input logic v);
		sda_oe_o = v;
	endtask
	// Both lines let go, whatever an unfinished frame left held
	task automatic idle();
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	endtask
	// Release clock; a stretching slave may keep it low
	task automatic rise();
		int n;
		n = 0;
		scl_oe_o = 1'b0;
		while (!scl_i && n < 1500)
		begin
			#10;
			n++;
		end
		if (!scl_i)
			stuck++;
		#40;
	endtask
	// Data moves 10 ns after clock fall so no false start is seen
	task automatic bit_io(input logic v, output logic s);
		#10;
		sda_oe_o = ~v;
		#30;
		rise();
		s = sda_i;
		scl_oe_o = 1'b1;
	endtask
	task automatic start();
		sda_oe_o = 1'b1;
		#40;
		scl_oe_o = 1'b1;
	endtask
	// MSB first, then a released ninth bit for the acknowledge
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], ack);
		bit_io(1'b1, ack);
	endtask
	task automatic stop();
		#10;
		sda_oe_o = 1'b1;
		#30;
		rise();
		sda_oe_o = 1'b0;
		#40;
	endtask
endmodule // bus_master_model
`default_nettype wire

// [tb/i2c_arbitration_address_monitor_tb_top.sv]
// Self-checking bench for the arbitration and address monitor
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Bench
module i2c_arbitration_address_monitor_tb_top;
	logic clock_i, rst_n_i, interface_mode_select_i, ack_clock_en_i;
	logic detection_disable_i, address_recognition_select_i;
	logic data_buffer_wr_i, data_buffer_rd_i, control_two_wr_i;
	logic cr2_master_select_i, cr2_transmitter_select_i;
	logic cr2_bus_busy_i, cr2_pending_service_i;
	logic [2:0] word_bit_count_i;
	logic [6:0] own_slave_address_i, own;
	logic [7:0] data_buffer_wdata_i, data_buffer_rdata_o, b;
	logic master_select_o, transmitter_select_o, bus_busy_bit_o;
	logic pending_service_o, arbitration_lost_flag_o, address_match_flag_o;
	logic general_call_flag_o, last_received_bit_o, serial_iface_irq_o;
	logic clock_line_pin_o, clock_line_pin_oe_o, data_line_pin_o;
	logic data_line_pin_oe_o, p_scl, p_sda, ack, dis, fmt, ea;
	wire clock_line_pin_i = ~(clock_line_pin_oe_o | p_scl);
	wire data_line_pin_i = ~(data_line_pin_oe_o | p_sda);
	int error_cnt, checked;
	i2c_arbitration_address_monitor dut (.*);
	bus_master_model p (.scl_i(clock_line_pin_i), .sda_i(data_line_pin_i),
		.scl_oe_o(p_scl), .sda_oe_o(p_sda));
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Strobes are one cycle; the extra cycle lets status settle
	task automatic buf_wr(input logic [7:0] d);
		data_buffer_wdata_i = d;
		data_buffer_wr_i = 1'b1;
		tick(1);
		data_buffer_wr_i = 1'b0;
		tick(1);
	endtask
	task automatic cr2(input logic [3:0] v);
		{cr2_master_select_i, cr2_transmitter_select_i, cr2_bus_busy_i,
			cr2_pending_service_i} = v;
		control_two_wr_i = 1'b1;
		tick(1);
		control_two_wr_i = 1'b0;
		tick(1);
	endtask
	// Count bus clock falls, bounded so a dead clock cannot hang
	task automatic wait_falls(input int k);
		logic was;
		int n;
		was = clock_line_pin_i;
		n = 0;
		for (int t = 0; t < 20000 && n < k; t++)
		begin
			tick(1);
			if (was && !clock_line_pin_i)
				n++;
			was = clock_line_pin_i;
		end
		cmp(8'(n), 8'(k));
	endtask
	// A row left without a stop may keep the model's clock low
	task automatic do_reset();
		rst_n_i = 1'b0;
		p.idle();
		tick(12);
		rst_n_i = 1'b1;
		tick(3);
	endtask
	// Main sequence
	initial
	begin
		{detection_disable_i, address_recognition_select_i, data_buffer_wr_i,
			data_buffer_rd_i, control_two_wr_i, cr2_master_select_i,
			cr2_transmitter_select_i, cr2_bus_busy_i, cr2_pending_service_i,
			word_bit_count_i, own_slave_address_i, data_buffer_wdata_i} = '0;
		{rst_n_i, interface_mode_select_i, ack_clock_en_i} = 3'b011;
		error_cnt = 0;
		checked = 0;
		void'($urandom(32'h17855689));
		for (int r = 0; r < 7; r++)
		begin
			own = 7'($urandom) | 7'h08;
			dis = (r == 3 || r == 4);
			fmt = (r == 5);
			case (r)
				0: b = {own, 1'b1};
				1, 3: b = {own, 1'b0};
				2, 4: b = 8'h00;
				5: b = 8'($urandom);
				default: b = {own ^ 7'h01, 1'b0};
			endcase
			detection_disable_i = dis;
			address_recognition_select_i = fmt;
			own_slave_address_i = own;
			do_reset();
			cmp(pending_service_o, 1'b1);
			p.start();
			tick(8);
			cmp(bus_busy_bit_o, 1'b1);
			p.send(b, ack);
			tick(8);
			ea = fmt | (!dis && (b == 8'h00 || b[7:1] == own));
			cmp(address_match_flag_o, ea);
			cmp(general_call_flag_o, !fmt && !dis && b == 8'h00);
			cmp(transmitter_select_o, !fmt && ea && b[0]);
			if (!fmt)
			begin
				cmp(pending_service_o, !ea);
				cmp(last_received_bit_o, !ea);
			end
			data_buffer_rd_i = 1'b1;
			tick(1);
			data_buffer_rd_i = 1'b0;
			tick(1);
			cmp(address_match_flag_o, 1'b0);
			if (r != 0)
			begin
				buf_wr(8'h00);
				cmp(pending_service_o, 1'b1);
				p.stop();
				tick(8);
				cmp(bus_busy_bit_o, 1'b0);
				cmp(general_call_flag_o, 1'b0);
			end
			$display("address row %0d done", r);
		end
		// Master sends an address read; far side acknowledges it
		do_reset();
		b = 8'($urandom) | 8'h01;
		buf_wr(b);
		cr2(4'hf);
		wait_falls(9);
		p.hold(1'b1);
		for (int n = 0; n < 2000 && serial_iface_irq_o !== 1'b1; n++)
			tick(1);
		cmp(serial_iface_irq_o, 1'b1);
		cmp(pending_service_o, 1'b0);
		cmp(last_received_bit_o, 1'b0);
		cmp(transmitter_select_o, !b[0]);
		cmp(master_select_o, 1'b1);
		cmp(arbitration_lost_flag_o, 1'b0);
		tick(2);
		cmp(clock_line_pin_oe_o, 1'b1);
		$display("master address test done");
		do_reset();
		cmp(bus_busy_bit_o, 1'b0);
		buf_wr(8'($urandom) | 8'h80);
		cr2(4'hf);
		tick(1);
		cmp(master_select_o, 1'b1);
		cmp(data_line_pin_oe_o, 1'b1);
		p.hold(1'b1);
		for (int n = 0; n < 3000 && arbitration_lost_flag_o !== 1'b1; n++)
			tick(1);
		tick(3);
		cmp(arbitration_lost_flag_o, 1'b1);
		cmp(master_select_o, 1'b0);
		cmp(transmitter_select_o, 1'b0);
		cmp(data_line_pin_oe_o, 1'b0);
		cr2(4'h0);
		cmp(arbitration_lost_flag_o, 1'b0);
		p.hold(1'b0);
		tick(8);
		cmp(bus_busy_bit_o, 1'b0);
		cmp(8'(p.stuck), 8'h00);
		$display("arbitration test done");
		final_report();
	end
endmodule // i2c_arbitration_address_monitor_tb_top
`default_nettype wire

// [tb/i2c_monitor_properties.sv]
// Concurrent checks on the arbitration and address monitor ports
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Checker
module i2c_monitor_properties (
	// Clock, reset and configuration
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic interface_mode_select_i,
	input wire logic detection_disable_i,
	// Software strobes
	input wire logic data_buffer_wr_i,
	input wire logic data_buffer_rd_i,
	input wire logic control_two_wr_i,
	input wire logic cr2_master_select_i,
	input wire logic cr2_transmitter_select_i,
	input wire logic cr2_bus_busy_i,
	input wire logic cr2_pending_service_i,
	// Status
	input wire logic master_select_o,
	input wire logic transmitter_select_o,
	input wire logic bus_busy_bit_o,
	input wire logic pending_service_o,
	input wire logic arbitration_lost_flag_o,
	input wire logic address_match_flag_o,
	input wire logic general_call_flag_o,
	input wire logic last_received_bit_o,
	input wire logic serial_iface_irq_o,
	// Bus lines
	input wire logic clock_line_pin_i,
	input wire logic clock_line_pin_oe_o,
	input wire logic data_line_pin_i,
	input wire logic data_line_pin_oe_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	// Data edges while the clock stays high frame a transfer
	sequence start_s;
		clock_line_pin_i && $past(clock_line_pin_i) && $fell(data_line_pin_i);
	endsequence
	sequence stop_s;
		clock_line_pin_i && $past(clock_line_pin_i) && $rose(data_line_pin_i);
	endsequence
	// Data held steady over a clock rise must land in the status bit
	property lrb_p(b);
		($rose(clock_line_pin_i) && data_line_pin_i == b)
		##1 (clock_line_pin_i && data_line_pin_i == b) [*2]
		|-> ##[0:4] last_received_bit_o == b;
	endproperty
	AST_LRB_ONE: assert property (lrb_p(1'b1))
		else $error("last bit misses a one");
	AST_LRB_ZERO: assert property (lrb_p(1'b0))
		else $error("last bit misses a zero");
	AST_BUSY_SET: assert property (interface_mode_select_i ##0 start_s
		|-> ##[1:5] bus_busy_bit_o) else $error("busy not set on start");
	AST_BUSY_CLR: assert property (interface_mode_select_i ##0 stop_s
		|-> ##[1:5] !bus_busy_bit_o) else $error("busy not cleared on stop");
	AST_GC_CLR: assert property ((start_s or stop_s)
		|-> ##[1:5] !general_call_flag_o) else $error("call flag kept");
	AST_AL_DROP: assert property ($rose(arbitration_lost_flag_o)
		|-> ##[0:2] !master_select_o && !transmitter_select_o)
		else $error("master kept after loss");
	AST_AL_FREE: assert property ($rose(arbitration_lost_flag_o)
		|-> ##[0:2] !data_line_pin_oe_o) else $error("data kept after loss");
	AST_AL_CLR: assert property (data_buffer_wr_i || data_buffer_rd_i
		|| control_two_wr_i |=> !arbitration_lost_flag_o)
		else $error("loss flag kept");
	AST_AAS_CLR: assert property (data_buffer_wr_i || data_buffer_rd_i
		|=> !address_match_flag_o) else $error("match flag kept");
	AST_DIS_GC: assert property ($rose(general_call_flag_o)
		|-> !$past(detection_disable_i)) else $error("call while disabled");
	AST_IRQ_PIN: assert property (serial_iface_irq_o
		|-> !pending_service_o) else $error("pending kept at irq");
	AST_HOLD: assert property (interface_mode_select_i && !pending_service_o
		&& !$past(pending_service_o, 4) |-> clock_line_pin_oe_o)
		else $error("clock not held");
	AST_PIN_SET: assert property (data_buffer_wr_i && !serial_iface_irq_o
		|=> pending_service_o) else $error("pending not set");
	AST_START: assert property (control_two_wr_i && cr2_master_select_i
		&& cr2_transmitter_select_i && cr2_bus_busy_i && cr2_pending_service_i
		&& !bus_busy_bit_o && interface_mode_select_i
		|-> ##[1:3] master_select_o && data_line_pin_oe_o)
		else $error("start not begun");
endmodule // i2c_monitor_properties

bind i2c_arbitration_address_monitor i2c_monitor_properties chk (.*);
`default_nettype wire
